//--- shared/pmbcmd_pkg.sv
// Package: command codes, field positions, reset values and types
package pmbcmd_pkg;
  localparam logic [7:0] CMD_OP = 8'h01;
  localparam logic [7:0] CMD_CFG = 8'h02;
  localparam logic [7:0] CMD_CLR = 8'h03;
  localparam logic [7:0] CMD_WP = 8'h10;
  localparam logic [7:0] CMD_STORE = 8'h11;
  localparam logic [7:0] CMD_RESTORE = 8'h12;
  localparam logic [7:0] CMD_VOUT = 8'h21;
  localparam logic [7:0] CMD_STB = 8'h78;
  localparam logic [7:0] CMD_SCML = 8'h7E;
  localparam logic [7:0] CMD_VEND = 8'hF0;
  // Start/stop configuration, operation, write protect and vendor fields
  localparam int CFG_PU = 4;
  localparam int CFG_CMD = 3;
  localparam int CFG_CPR = 2;
  localparam int CFG_POL = 1;
  localparam int CFG_CPA = 0;
  localparam int OP_ON = 7;
  localparam int OP_OFF = 6;
  localparam int WP_B7 = 7;
  localparam int WP_B6 = 6;
  localparam int WP_B5 = 5;
  localparam int VEND_OVR = 0;
  // Status fields
  localparam int SB_OV = 5;
  localparam int SB_OC = 4;
  localparam int SB_CML = 1;
  localparam int SC_IVD = 6;
  localparam int SC_MEM = 4;
  // Reset values and writable masks
  localparam logic [4:0] CFG_RST = 5'h16;
  localparam logic [7:0] WP_RST = 8'h00;
  localparam logic [7:0] OP_RST = 8'h00;
  localparam logic [7:0] VEND_RST = 8'h00;
  localparam logic [15:0] VOUT_RST = 16'h0000;
  localparam logic [7:0] OP_WMASK = 8'hFC;
  localparam logic [7:0] WP_WMASK = 8'hE0;
  // Timing
  localparam int CLK_MHZ = 10;
  localparam int NVM_BUSY_MS = 100;
  localparam int NVM_BUSY_CYC = NVM_BUSY_MS * 1000 * CLK_MHZ;
  localparam int CONTROL_PIN_LOW_NS = 100;
  localparam int CONTROL_PIN_LOW_CYC = (CONTROL_PIN_LOW_NS * CLK_MHZ + 999) / 1000;
  typedef struct packed {
    logic write;
    logic [7:0] code;
    logic [15:0] data;
  } pmbcmd_req_s;
  typedef struct packed {
    logic ack;
    logic [15:0] data;
  } pmbcmd_resp_s;
  typedef struct packed {
    logic [7:0] wp;
    logic [4:0] cfg;
    logic [7:0] op;
    logic [15:0] vout;
    logic [7:0] vend;
  } pmbcmd_nvm_s;
endpackage : pmbcmd_pkg

//--- hdl/pmbcmd_core.sv
// PMBus start/stop, fault clear, write protect and nonvolatile command logic
`timescale 1ns/1ns
// Behaviour
// R1: auto start off: run whenever input present
// R2: auto start on: wait for pin/command
// R3: command field selects obeying OPERATION on
// R4: pin field selects requiring control pin
// R5: polarity field sets pin active level
// R6: polarity takes effect only after reboot
// R7: pin off: soft or immediate by field
// R8: clear faults wipes status, drops alert
// R9: clear faults never restarts latched unit
// R10: persisting fault sets its bit again
// R11: host waits before clearing faults
// R12: overvoltage latch holds low-side switch
// R13: pin low pulse over 100 ns
// R14: reads always allowed regardless of protection
// R15: restore skips protected registers
// R16: three protection levels limit writes
// R17: several protect bits: alert, no protection
// R18: store copies settings to nonvolatile memory
// R19: store ignores faults, bus busy 100 ms
// R20: store failure: NACK, cml and mem
// R21: restore reloads unprotected registers
// R22: restore halts switching and restarts
// R23: on bit needs input, gating, no fault
// R24: default pin only, active high, soft
// R25: blocked writes are discarded
module pmbcmd_core #(
  parameter int NVM_BUSY_CYCLES = pmbcmd_pkg::NVM_BUSY_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic lk_clk,
  input wire logic lk_srst,
  input wire logic lk_req_valid,
  input wire pmbcmd_pkg::pmbcmd_req_s lk_req,
  output logic lk_req_ready,
  output logic lk_resp_valid,
  output pmbcmd_pkg::pmbcmd_resp_s lk_resp,
  input wire logic control_pin,
  input wire logic vin_ok,
  input wire logic feedback_pin_low,
  input wire logic fault_ov,
  input wire logic fault_oc,
  input wire logic ov_latch_resp,
  input wire logic oc_latch_resp,
  input wire pmbcmd_pkg::pmbcmd_nvm_s nvm_boot,
  input wire pmbcmd_pkg::pmbcmd_nvm_s nvm_rdata,
  input wire logic nvm_done,
  input wire logic nvm_error,
  output logic nvm_store_req,
  output logic nvm_restore_req,
  output pmbcmd_pkg::pmbcmd_nvm_s nvm_wdata,
  output logic switch_en,
  output logic off_immediate,
  output logic low_side_switch_on,
  output logic alert
);
  import pmbcmd_pkg::*;
  localparam int TW = $clog2(NVM_BUSY_CYCLES + 1);
  typedef enum logic [1:0] {PMBCMD_IDLE, PMBCMD_STORE, PMBCMD_RESTORE} pmbcmd_state_e;

  // Link side: holds a request stable until the core answers
  logic lk_pend;
  logic lk_tgl;
  pmbcmd_req_s lk_hold;
  logic lk_dn1, lk_dn2, lk_dn3;
  logic done_tgl;
  pmbcmd_resp_s core_resp;
  wire lk_take = lk_req_valid & ~lk_pend;
  wire lk_done_ev = lk_dn2 ^ lk_dn3;
  assign lk_req_ready = ~lk_pend; // R19

  always_ff @(posedge lk_clk) begin
    if (lk_srst) begin
      lk_pend <= 1'b0;
      lk_tgl <= 1'b0;
      lk_hold <= '0;
      {lk_dn1, lk_dn2, lk_dn3} <= 3'h0;
      lk_resp_valid <= 1'b0;
      lk_resp <= '0;
    end else begin
      {lk_dn1, lk_dn2, lk_dn3} <= {done_tgl, lk_dn1, lk_dn2};
      lk_resp_valid <= lk_done_ev;
      if (lk_done_ev) lk_resp <= core_resp;
      if (lk_take) begin
        lk_hold <= lk_req;
        lk_tgl <= ~lk_tgl;
        lk_pend <= 1'b1;
      end else if (lk_done_ev) begin
        lk_pend <= 1'b0;
      end
    end
  end

  // Core side synchronisers: request toggle and the pins
  logic rq1, rq2, rq3;
  logic [4:0] pin1, pin2;
  always_ff @(posedge clk) begin
    if (srst) begin
      {rq1, rq2, rq3} <= 3'h0;
      pin1 <= 5'h00;
      pin2 <= 5'h00;
    end else begin
      {rq1, rq2, rq3} <= {lk_tgl, rq1, rq2};
      pin1 <= {control_pin, vin_ok, feedback_pin_low, fault_ov, fault_oc};
      pin2 <= pin1;
    end
  end
  wire pin_s = pin2[4];
  wire vin_s = pin2[3];
  wire fb_s = pin2[2];
  wire fov_s = pin2[1];
  wire foc_s = pin2[0];
  wire req_new = rq2 ^ rq3;

  // Settings and state
  logic [7:0] op, wp, vend;
  logic [4:0] cfg;
  logic [15:0] vout;
  logic boot_pend, pol_active;
  logic flt_ov, flt_oc, cml, ivd, mem;
  logic latched_off;
  logic [7:0] low_cnt;
  pmbcmd_state_e st;
  logic [TW-1:0] cnt;
  logic nv_seen, nv_err;

  // Protection level is valid only with exactly one bit set
  wire lvl7 = wp[WP_B7] & ~wp[WP_B6] & ~wp[WP_B5]; // R16 R17
  wire lvl6 = ~wp[WP_B7] & wp[WP_B6] & ~wp[WP_B5];
  wire lvl5 = ~wp[WP_B7] & ~wp[WP_B6] & wp[WP_B5];
  function automatic logic wr_allowed(input logic [7:0] c, input logic l7,
                                      input logic l6, input logic l5);
    wr_allowed = (c == CMD_WP) | ~(l7 | l6 | l5) | ((l6 | l5) & (c == CMD_OP))
      | (l5 & ((c == CMD_CFG) | (c == CMD_VOUT))); // R16
  endfunction : wr_allowed

  // Command decode
  wire [7:0] code = lk_hold.code;
  wire [15:0] wd = lk_hold.data;
  wire rd_known = (code == CMD_OP) | (code == CMD_CFG) | (code == CMD_WP)
    | (code == CMD_VOUT) | (code == CMD_STB) | (code == CMD_SCML) | (code == CMD_VEND);
  wire wr_known = rd_known | (code == CMD_CLR) | (code == CMD_STORE) | (code == CMD_RESTORE);
  wire is_wr = req_new & lk_hold.write;
  // Restore is never refused; protection is applied per register when it loads
  wire wr_ok = is_wr & wr_known
    & (wr_allowed(code, lvl7, lvl6, lvl5) | (code == CMD_RESTORE)); // R25 R15
  wire wr_op = wr_ok & (code == CMD_OP);
  wire wr_cfg = wr_ok & (code == CMD_CFG);
  wire wr_wp = wr_ok & (code == CMD_WP);
  wire wr_vout = wr_ok & (code == CMD_VOUT);
  wire wr_vend = wr_ok & (code == CMD_VEND);
  wire clr_go = wr_ok & (code == CMD_CLR); // R8
  wire store_go = wr_ok & (code == CMD_STORE); // R18
  wire restore_go = wr_ok & (code == CMD_RESTORE); // R21
  wire wp_bad = wr_wp & (32'($countones(wd[WP_B7:WP_B5])) > 32'd1); // R17

  // Nonvolatile operation end: answer held back for the busy time
  wire finish = (st != PMBCMD_IDLE) & (nv_seen | nvm_done)
    & (cnt >= TW'(NVM_BUSY_CYCLES - 1)); // R19
  wire err_now = nv_err | (nvm_done & nvm_error);
  wire nv_fail = finish & (st == PMBCMD_STORE) & err_now; // R20
  wire restore_ld = finish & (st == PMBCMD_RESTORE) & ~err_now;
  wire storing = (st == PMBCMD_STORE);
  wire restoring = (st == PMBCMD_RESTORE);

  // Restore only touches registers the current level leaves writable
  wire ld_op = restore_ld & wr_allowed(CMD_OP, lvl7, lvl6, lvl5); // R15
  wire ld_cfg = restore_ld & wr_allowed(CMD_CFG, lvl7, lvl6, lvl5);
  wire ld_vout = restore_ld & wr_allowed(CMD_VOUT, lvl7, lvl6, lvl5);
  wire ld_vend = restore_ld & wr_allowed(CMD_VEND, lvl7, lvl6, lvl5);
  wire [7:0] next_op = ld_op ? nvm_rdata.op : wr_op ? (wd[7:0] & OP_WMASK) : op;
  wire [4:0] next_cfg = ld_cfg ? nvm_rdata.cfg : wr_cfg ? wd[4:0] : cfg;
  wire [7:0] next_wp = restore_ld ? nvm_rdata.wp : wr_wp ? (wd[7:0] & WP_WMASK) : wp;
  wire [15:0] next_vout = ld_vout ? nvm_rdata.vout : wr_vout ? wd : vout;
  wire [7:0] next_vend = ld_vend ? nvm_rdata.vend : wr_vend ? wd[7:0] : vend;

  // Settings registers; boot load comes from the stored image
  always_ff @(posedge clk) begin
    if (srst) begin
      op <= OP_RST;
      cfg <= CFG_RST; // R24
      wp <= WP_RST;
      vout <= VOUT_RST;
      vend <= VEND_RST;
      boot_pend <= 1'b1;
      pol_active <= CFG_RST[CFG_POL];
    end else if (boot_pend) begin
      {wp, cfg, op, vout, vend} <= nvm_boot;
      pol_active <= nvm_boot.cfg[CFG_POL]; // R6
      boot_pend <= 1'b0;
    end else begin
      op <= next_op;
      cfg <= next_cfg;
      wp <= next_wp;
      vout <= next_vout;
      vend <= next_vend;
    end
  end
  assign nvm_wdata = {wp, cfg, op, vout, vend};

  // Store and restore sequencer
  always_ff @(posedge clk) begin
    if (srst) begin
      st <= PMBCMD_IDLE;
      cnt <= '0;
      nv_seen <= 1'b0;
      nv_err <= 1'b0;
      nvm_store_req <= 1'b0;
      nvm_restore_req <= 1'b0;
    end else begin
      nvm_store_req <= store_go; // R18
      nvm_restore_req <= restore_go; // R21
      case (st)
        PMBCMD_IDLE: begin
          cnt <= '0;
          nv_seen <= 1'b0;
          nv_err <= 1'b0;
          if (store_go) st <= PMBCMD_STORE;
          else if (restore_go) st <= PMBCMD_RESTORE;
        end
        PMBCMD_STORE, PMBCMD_RESTORE: begin
          if (cnt < TW'(NVM_BUSY_CYCLES - 1)) cnt <= cnt + 1'b1;
          if (nvm_done) nv_seen <= 1'b1;
          if (nvm_done & nvm_error) nv_err <= 1'b1;
          if (finish) st <= PMBCMD_IDLE;
        end
        default: st <= PMBCMD_IDLE;
      endcase
    end
  end

  // Answer: immediate for plain commands, after the busy time for NVM ones
  wire resp_now = req_new & ~store_go & ~restore_go;
  wire [7:0] stb = {2'h0, flt_ov, flt_oc, 2'h0, cml, 1'b0};
  wire [7:0] scml = {1'b0, ivd, 1'b0, mem, 4'h0};
  wire [15:0] rd_data = (code == CMD_OP) ? {8'h00, op} // R14
    : (code == CMD_CFG) ? {11'h000, cfg}
    : (code == CMD_WP) ? {8'h00, wp}
    : (code == CMD_VOUT) ? vout
    : (code == CMD_STB) ? {8'h00, stb}
    : (code == CMD_SCML) ? {8'h00, scml}
    : (code == CMD_VEND) ? {8'h00, vend} : 16'h0000;
  always_ff @(posedge clk) begin
    if (srst) begin
      core_resp <= '0;
      done_tgl <= 1'b0;
    end else if (resp_now) begin
      core_resp.ack <= lk_hold.write ? wr_known : rd_known;
      core_resp.data <= lk_hold.write ? 16'h0000 : rd_data;
      done_tgl <= ~done_tgl;
    end else if (finish) begin
      core_resp.ack <= ~nv_fail; // R20
      core_resp.data <= 16'h0000;
      done_tgl <= ~done_tgl;
    end
  end

  // Faults are ignored while a store runs; set beats clear
  wire eov = fov_s & ~storing; // R19
  wire eoc = foc_s & ~storing;
  wire cml_set = wp_bad | nv_fail; // R17 R20
  wire next_flt_ov = eov | (flt_ov & ~clr_go); // R8 R10
  wire next_flt_oc = eoc | (flt_oc & ~clr_go); // R10
  wire next_cml = cml_set | (cml & ~clr_go);
  wire next_ivd = wp_bad | (ivd & ~clr_go);
  wire next_mem = nv_fail | (mem & ~clr_go);
  always_ff @(posedge clk) begin
    if (srst) begin
      {flt_ov, flt_oc, cml, ivd, mem} <= 5'h00;
      alert <= 1'b0;
    end else begin
      {flt_ov, flt_oc, cml, ivd, mem} <= {next_flt_ov, next_flt_oc, next_cml, next_ivd, next_mem};
      alert <= next_flt_ov | next_flt_oc | next_cml | next_ivd | next_mem; // R8
    end
  end

  // Control pin level and its low-pulse fault release
  wire pin_act = pol_active ? pin_s : ~pin_s; // R5
  wire pin_clear = pin_act & (low_cnt >= 8'(CONTROL_PIN_LOW_CYC)); // R13
  wire latch_set = (eov & ov_latch_resp) | (eoc & oc_latch_resp);
  wire next_lo = latch_set | (latched_off & ~pin_clear); // R9
  wire ls_rel = vend[VEND_OVR] & fb_s;
  wire next_ls = (eov & ov_latch_resp) | (low_side_switch_on & ~clr_go & ~ls_rel); // R12

  // Start gating from the configuration fields
  wire pin_ok = ~cfg[CFG_CPR] | pin_act; // R4
  wire cmd_ok = ~cfg[CFG_CMD] | op[OP_ON]; // R3 R23
  wire gate_on = ~cfg[CFG_PU] | (pin_ok & cmd_ok); // R1 R2
  wire next_sw = vin_s & gate_on & ~next_lo & ~restoring; // R22 R23
  wire pin_cause = cfg[CFG_PU] & cfg[CFG_CPR] & ~pin_act;
  wire next_imm = pin_cause ? cfg[CFG_CPA] : ~op[OP_OFF]; // R7

  always_ff @(posedge clk) begin
    if (srst) begin
      latched_off <= 1'b0;
      low_side_switch_on <= 1'b0;
      low_cnt <= 8'h00;
      switch_en <= 1'b0;
      off_immediate <= 1'b0;
    end else begin
      latched_off <= next_lo;
      low_side_switch_on <= next_ls;
      low_cnt <= pin_act ? 8'h00 : (low_cnt == 8'hFF) ? low_cnt : low_cnt + 8'h01;
      switch_en <= next_sw;
      off_immediate <= next_imm;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_clear_alert;
    clr_go & ~eov & ~eoc & ~cml_set |=> ~alert;
  endproperty
  a_clear_alert: assert property (p_clear_alert) else $error("alert kept after clear"); // R8
  property p_refault;
    clr_go & eov |=> flt_ov & alert;
  endproperty
  a_refault: assert property (p_refault) else $error("persisting fault lost"); // R10
  property p_latch_hold;
    latched_off & clr_go & ~pin_clear |=> latched_off ##0 ~switch_en;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("clear restarted unit"); // R9
  property p_auto_start;
    ~cfg[CFG_PU] & vin_s & ~next_lo & ~restoring & ~boot_pend |=> switch_en;
  endproperty
  a_auto_start: assert property (p_auto_start) else $error("auto start failed"); // R1
  property p_pin_gate;
    cfg[CFG_PU] & cfg[CFG_CPR] & ~pin_act |=> ~switch_en;
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("ran without pin"); // R4
  property p_wp_bad;
    wp_bad |=> cml & ivd & alert ##0 wr_allowed(CMD_VEND, lvl7, lvl6, lvl5);
  endproperty
  a_wp_bad: assert property (p_wp_bad) else $error("bad protect not flagged"); // R17
  property p_blocked;
    is_wr & (code == CMD_CFG) & (lvl7 | lvl6) & ~boot_pend & ~restore_ld |=> $stable(cfg);
  endproperty
  a_blocked: assert property (p_blocked) else $error("blocked write stored"); // R25
  property p_pol_fixed;
    ~boot_pend |=> $stable(pol_active);
  endproperty
  a_pol_fixed: assert property (p_pol_fixed) else $error("polarity changed live"); // R6
  property p_store_busy;
    store_go |=> nvm_store_req ##1 storing [*8];
  endproperty
  a_store_busy: assert property (p_store_busy) else $error("store ended early"); // R18 R19
  property p_store_fail;
    nv_fail |=> cml & mem & ~core_resp.ack;
  endproperty
  a_store_fail: assert property (p_store_fail) else $error("store failure unflagged"); // R20
  property p_restore_prot;
    restore_ld & lvl7 |=> $stable(op) & $stable(cfg) & $stable(vout);
  endproperty
  a_restore_prot: assert property (p_restore_prot) else $error("protected reg reloaded"); // R15
  property p_restore_load;
    ld_cfg |=> cfg == $past(nvm_rdata.cfg);
  endproperty
  a_restore_load: assert property (p_restore_load) else $error("restore not loaded"); // R21
  property p_ls_hold;
    low_side_switch_on & ~clr_go & ~ls_rel |=> low_side_switch_on;
  endproperty
  a_ls_hold: assert property (p_ls_hold) else $error("low-side released early"); // R12
  c_store: cover property (store_go ##1 storing [*4]);
  c_clear: cover property (clr_go & flt_ov);
  c_pin_release: cover property (latched_off ##1 pin_clear);
  c_protected_restore: cover property (restore_ld & lvl7);
endmodule : pmbcmd_core

//--- bench/pmbcmd_host.sv
// Host model of the command link: one request at a time, waits for each answer
`timescale 1ns/1ns
module pmbcmd_host (
  input wire logic lk_clk,
  input wire logic lk_req_ready,
  input wire logic lk_resp_valid,
  input wire pmbcmd_pkg::pmbcmd_resp_s lk_resp,
  output logic lk_req_valid,
  output pmbcmd_pkg::pmbcmd_req_s lk_req
);
  import pmbcmd_pkg::*;

  // Idle lines at time zero
  initial begin
    lk_req_valid = 1'b0;
    lk_req = '0;
  end

  // Offer, hold until taken, then scramble the released lines so stale data never helps
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output pmbcmd_resp_s r);
    r = 'x;
    @(posedge lk_clk);
    lk_req_valid <= 1'b1;
    lk_req <= {w, c, d};
    @(posedge lk_clk iff lk_req_ready);
    lk_req_valid <= 1'b0;
    lk_req <= ~lk_req;
    // Bounded wait; a missing answer leaves r unknown so the caller's compare fails
    for (int i = 0; i < 600; i++) begin
      @(posedge lk_clk);
      if (lk_resp_valid) begin
        r = lk_resp;
        break;
      end
    end
  endtask : xfer
endmodule : pmbcmd_host

//--- bench/tb_top.sv
// Testbench for start/stop, fault clear, write protect and nonvolatile commands
`timescale 1ns/1ns
module tb_top;
  import pmbcmd_pkg::*;
  logic clk = 1'b0;
  logic lk_clk = 1'b0;
  logic srst = 1'b1;
  logic lk_srst = 1'b1;
  logic lk_req_valid, lk_req_ready, lk_resp_valid;
  pmbcmd_req_s lk_req;
  pmbcmd_resp_s lk_resp, rsp;
  logic control_pin = 1'b0;
  logic vin_ok = 1'b1;
  logic feedback_pin_low = 1'b0;
  logic fault_ov = 1'b0;
  logic fault_oc = 1'b0;
  pmbcmd_nvm_s boot_img = {WP_RST, CFG_RST, OP_RST, VOUT_RST, VEND_RST};
  pmbcmd_nvm_s nvm_rdata = {WP_RST, CFG_RST, OP_RST, VOUT_RST, VEND_RST};
  pmbcmd_nvm_s nvm_wdata, saved;
  logic nvm_done = 1'b0;
  logic nvm_fail = 1'b0;
  logic nvm_error, nvm_store_req, nvm_restore_req;
  logic switch_en, off_immediate, low_side_switch_on, alert;
  logic [2:0] nvm_cnt = 3'h0;
  int n_mismatch = 0;
  int checked = 0;

  // Clocks; the link clock has no fixed phase relation to the core clock
  always #50 clk = ~clk;
  always #16 lk_clk = ~lk_clk;

  pmbcmd_core #(.NVM_BUSY_CYCLES(20)) dut_u (
    .clk(clk), .srst(srst), .lk_clk(lk_clk), .lk_srst(lk_srst),
    .lk_req_valid(lk_req_valid), .lk_req(lk_req), .lk_req_ready(lk_req_ready),
    .lk_resp_valid(lk_resp_valid), .lk_resp(lk_resp), .control_pin(control_pin),
    .vin_ok(vin_ok), .feedback_pin_low(feedback_pin_low), .fault_ov(fault_ov),
    .fault_oc(fault_oc), .ov_latch_resp(1'b1), .oc_latch_resp(1'b1),
    .nvm_boot(boot_img), .nvm_rdata(nvm_rdata), .nvm_done(nvm_done),
    .nvm_error(nvm_error), .nvm_store_req(nvm_store_req),
    .nvm_restore_req(nvm_restore_req), .nvm_wdata(nvm_wdata), .switch_en(switch_en),
    .off_immediate(off_immediate), .low_side_switch_on(low_side_switch_on), .alert(alert));

  pmbcmd_host host_u (
    .lk_clk(lk_clk), .lk_req_ready(lk_req_ready), .lk_resp_valid(lk_resp_valid),
    .lk_resp(lk_resp), .lk_req_valid(lk_req_valid), .lk_req(lk_req));

  // Memory stand-in: captures the stored image, answers three cycles after a request
  always @(posedge clk) begin
    nvm_done <= 1'b0;
    if (nvm_store_req) saved <= nvm_wdata;
    if (nvm_store_req || nvm_restore_req) nvm_cnt <= 3'h3;
    else if (nvm_cnt != 3'h0) begin
      nvm_cnt <= nvm_cnt - 3'h1;
      nvm_done <= (nvm_cnt == 3'h1);
    end
  end
  assign nvm_error = nvm_fail & nvm_done;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    host_u.xfer(1'b1, c, d, rsp);
  endtask : wr

  task automatic rdchk(input logic [7:0] c, input logic [15:0] m, input logic [15:0] e,
                       input string what);
    host_u.xfer(1'b0, c, 16'h0000, rsp);
    chk(rsp.data & m, e, what);
  endtask : rdchk

  // Pin and fault inputs pass a two-stage sync, so allow six cycles to settle
  task automatic settle;
    repeat (6) @(posedge clk);
  endtask : settle

  task automatic pin(input logic v);
    @(posedge clk) control_pin <= v;
    settle();
  endtask : pin

  task automatic t_defaults;
    rdchk(CMD_CFG, 16'h001F, 16'h0016, "cfg reset");
    rdchk(CMD_WP, 16'h00FF, 16'h0000, "wp reset");
    pin(1'b1);
    chk(16'(switch_en), 16'h0001, "pin start");
    pin(1'b0);
    chk(16'(switch_en), 16'h0000, "pin stop");
    chk(16'(off_immediate), 16'h0000, "soft off");
  endtask : t_defaults

  task automatic t_cfg;
    wr(CMD_CFG, 16'h0017);
    pin(1'b1);
    pin(1'b0);
    chk(16'(off_immediate), 16'h0001, "hard off");
    wr(CMD_CFG, 16'h0014);
    pin(1'b1);
    chk(16'(switch_en), 16'h0001, "polarity held");
    pin(1'b0);
    wr(CMD_CFG, 16'h0006);
    settle();
    chk(16'(switch_en), 16'h0001, "auto start");
    wr(CMD_CFG, 16'h0018);
    settle();
    chk(16'(switch_en), 16'h0000, "held off");
    wr(CMD_OP, 16'h0080);
    settle();
    chk(16'(switch_en), 16'h0001, "on bit start");
    wr(CMD_CFG, 16'h001E);
    settle();
    chk(16'(switch_en), 16'h0000, "pin needed");
    pin(1'b1);
    chk(16'(switch_en), 16'h0001, "pin and on bit");
    wr(CMD_OP, 16'h0000);
    settle();
    chk(16'(switch_en), 16'h0000, "on bit obeyed");
    wr(CMD_CFG, 16'h0016);
    settle();
    chk(16'(switch_en), 16'h0001, "on bit ignored");
  endtask : t_cfg

  task automatic t_faults;
    @(posedge clk) fault_oc <= 1'b1;
    settle();
    chk({14'h0000, switch_en, alert}, 16'h0001, "oc latch");
    @(posedge clk) fault_oc <= 1'b0;
    settle();
    wr(CMD_CLR, 16'h0000);
    chk({14'h0000, switch_en, alert}, 16'h0000, "clear no restart");
    rdchk(CMD_STB, 16'h00FF, 16'h0000, "status cleared");
    @(posedge clk) fault_oc <= 1'b1;
    settle();
    wr(CMD_CLR, 16'h0000);
    settle();
    chk(16'(alert), 16'h0001, "fault persists");
    rdchk(CMD_STB, 16'h0010, 16'h0010, "oc bit again");
    @(posedge clk) fault_oc <= 1'b0;
    wr(CMD_CLR, 16'h0000);
    pin(1'b0);
    pin(1'b1);
    chk(16'(switch_en), 16'h0001, "pin restart");
    @(posedge clk) fault_ov <= 1'b1;
    settle();
    @(posedge clk) fault_ov <= 1'b0;
    settle();
    chk(16'(low_side_switch_on), 16'h0001, "ov latch held");
    wr(CMD_CLR, 16'h0000);
    settle();
    chk(16'(low_side_switch_on), 16'h0000, "ov clear");
    wr(CMD_VEND, 16'h0001);
    @(posedge clk) fault_ov <= 1'b1;
    settle();
    @(posedge clk) fault_ov <= 1'b0;
    feedback_pin_low <= 1'b1;
    settle();
    chk(16'(low_side_switch_on), 16'h0000, "feedback release");
    feedback_pin_low <= 1'b0;
    wr(CMD_CLR, 16'h0000);
    pin(1'b0);
  endtask : t_faults

  task automatic t_wp;
    logic [7:0] lv;
    for (int i = 0; i < 3; i++) begin
      lv = 8'h80 >> i;
      wr(CMD_WP, {8'h00, lv});
      wr(CMD_OP, 16'h0080);
      wr(CMD_CFG, 16'h0017);
      chk(16'(rsp.ack), 16'h0001, "write ack");
      rdchk(CMD_OP, 16'h00FF, (i > 0) ? 16'h0080 : 16'h0000, "op level");
      rdchk(CMD_CFG, 16'h001F, (i == 2) ? 16'h0017 : 16'h0016, "cfg level");
      rdchk(CMD_WP, 16'h00FF, {8'h00, lv}, "wp read");
      wr(CMD_WP, 16'h0000);
      wr(CMD_OP, 16'h0000);
      wr(CMD_CFG, 16'h0016);
    end
    wr(CMD_WP, 16'h00C0);
    wr(CMD_CFG, 16'h0017);
    rdchk(CMD_CFG, 16'h001F, 16'h0017, "invalid wp open");
    rdchk(CMD_STB, 16'h0002, 16'h0002, "invalid wp cml");
    chk(16'(alert), 16'h0001, "invalid wp alert");
    wr(CMD_WP, 16'h0000);
    wr(CMD_CFG, 16'h0016);
    wr(CMD_CLR, 16'h0000);
  endtask : t_wp

  task automatic t_store;
    wr(CMD_CFG, 16'h0014);
    fork
      wr(CMD_STORE, 16'h0000);
      begin
        @(posedge nvm_store_req);
        @(posedge clk) fault_oc <= 1'b1;
        repeat (8) @(posedge clk);
        chk(16'(alert), 16'h0000, "fault ignored");
        chk(16'(lk_req_ready), 16'h0000, "bus busy");
      end
    join
    chk({3'h0, saved.cfg, saved.wp}, 16'h1400, "stored image");
    settle();
    chk(16'(alert), 16'h0001, "fault after store");
    @(posedge clk) fault_oc <= 1'b0;
    nvm_fail <= 1'b1;
    wr(CMD_STORE, 16'h0000);
    chk(16'(rsp.ack), 16'h0000, "store nack");
    rdchk(CMD_STB, 16'h0002, 16'h0002, "store cml");
    rdchk(CMD_SCML, 16'h0010, 16'h0010, "store mem");
    @(posedge clk) nvm_fail <= 1'b0;
    wr(CMD_CLR, 16'h0000);
    wr(CMD_CFG, 16'h0016);
  endtask : t_store

  task automatic t_restore;
    @(posedge clk) nvm_rdata.cfg <= 5'h17;
    pin(1'b1);
    wr(CMD_WP, 16'h0080);
    wr(CMD_RESTORE, 16'h0000);
    chk(16'(rsp.ack), 16'h0001, "protected restore ack");
    rdchk(CMD_CFG, 16'h001F, 16'h0016, "protected cfg kept");
    rdchk(CMD_WP, 16'h00FF, 16'h0000, "wp reloaded");
    fork
      wr(CMD_RESTORE, 16'h0000);
      begin
        @(posedge nvm_restore_req);
        repeat (4) @(posedge clk);
        chk(16'(switch_en), 16'h0000, "restore halts");
      end
    join
    rdchk(CMD_CFG, 16'h001F, 16'h0017, "restored cfg");
    settle();
    chk(16'(switch_en), 16'h0001, "restart");
  endtask : t_restore

  // Power cycle on the stored image; both domains reset so the toggles stay paired
  task automatic t_reboot;
    @(posedge clk) boot_img <= saved;
    srst <= 1'b1;
    lk_srst <= 1'b1;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge lk_clk) lk_srst <= 1'b0;
    repeat (4) @(posedge clk);
    pin(1'b0);
    chk(16'(switch_en), 16'h0001, "stored polarity active");
    pin(1'b1);
    chk(16'(switch_en), 16'h0000, "stored polarity off");
  endtask : t_reboot

  task automatic test_done;
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge lk_clk) lk_srst <= 1'b0;
    repeat (4) @(posedge clk);
    t_defaults();
    t_cfg();
    t_faults();
    t_wp();
    t_store();
    t_restore();
    t_reboot();
    test_done();
  end

  // Watchdog, far beyond the several hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    test_done();
  end
endmodule : tb_top
